// ==== design/wsv_validator.v ====
// Summary of operation
// - Offers sine, square, triangle, ramp, noise, plus arbitrary-waveform selection.
// - Arbitrary source is one of five built-ins or user-downloaded data.
// - Shape is sine after reset.
// - Shape change lowering max frequency clamps frequency and reports -221.
// - In rms or dBm units, shape change clamps excess amplitude, reports -221.
// - Noise refused as modulation carrier; any shape except dc may be modulating wave.
// - Changing to a shape the active modulation forbids turns modulation off.
// - AM, FM, FSK and burst accepted on permitted carriers including arbitrary.
// - Linear or log sweep accepted for all shapes except noise and dc.
// - Sine and square up to 15 MHz, ramp and triangle 100 kHz, minimum 100 uHz.
// - Built-in arbitrary waveforms limited to 5 MHz.
// - User waveform maximum 5, 2.5 or 0.2 MHz by points; minimum 100 mHz.
// - Frequency is 1 kHz until one is set.
// - Square duty 40-60% above 5 MHz, else 20-80%.
// - Frequency making duty invalid moves duty to nearest limit, reports -221.
// - Shape select accepts exactly sine, square, triangle, ramp, noise, user, dc.
// - Combined setup sets shape, frequency, amplitude, offset; resets duty, mode, trigger.
// - Errors queue up; indicator while non-empty; empty queue reads zero.
//
// Chosen here: the placing of the registers and the APB register port.
`include "wsv_consts.vh"

module wsv_validator (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [2:0]  shape_r,
	output reg  [39:0] freq_r,
	output reg  [7:0]  duty_r,
	output reg  [15:0] amp_r,
	output reg  [2:0]  mod_mode_r,
	output reg         err_pending_r
);

	localparam S_IDLE = 2'd0;
	localparam S_FREQ = 2'd1;
	localparam S_DUTY = 2'd2;
	localparam S_AMP  = 2'd3;

	// Staged frequency words restart at the default setting
	localparam [39:0] F_DEF = `WSV_F_1K;

	// ==========================================
	// Limit tables
	function [39:0] f_max;
		input [2:0]  shp;
		input        usr;
		input [13:0] pts;
		begin
			case (shp)
				`WSV_SH_SINE, `WSV_SH_SQUARE: f_max = `WSV_F_15M;
				`WSV_SH_TRI, `WSV_SH_RAMP:    f_max = `WSV_F_100K;
				`WSV_SH_USER: begin
					if (!usr)
						f_max = `WSV_F_5M;
					else if (pts <= `WSV_PTS_8K)
						f_max = `WSV_F_5M;
					else if (pts <= `WSV_PTS_12K)
						f_max = `WSV_F_2M5;
					else
						f_max = `WSV_F_200K;
				end
				default: f_max = `WSV_F_NONE_HI;
			endcase
		end
	endfunction

	function [39:0] f_min;
		input [2:0] shp;
		input       usr;
		begin
			case (shp)
				`WSV_SH_NOISE, `WSV_SH_DC: f_min = `WSV_F_NONE_LO;
				`WSV_SH_USER: f_min = usr ? `WSV_F_MIN_USER : `WSV_F_MIN_STD;
				default: f_min = `WSV_F_MIN_STD;
			endcase
		end
	endfunction

	// Vpp ceilings are equal for all shapes, so only rms and dBm need a table
	function [15:0] a_max;
		input [2:0] shp;
		input [1:0] unit;
		begin
			case (shp)
				`WSV_SH_SQUARE:
					a_max = (unit == `WSV_U_VRMS) ? `WSV_AR_SQUARE : `WSV_AD_SQUARE;
				`WSV_SH_TRI, `WSV_SH_RAMP:
					a_max = (unit == `WSV_U_VRMS) ? `WSV_AR_TRI : `WSV_AD_TRI;
				default:
					a_max = (unit == `WSV_U_VRMS) ? `WSV_AR_SINE : `WSV_AD_SINE;
			endcase
			if (unit == `WSV_U_VPP || shp == `WSV_SH_DC)
				a_max = `WSV_A_NOLIM;
		end
	endfunction

	// ==========================================
	// State
	reg [1:0]  state_r;
	reg        chk_amp_r;
	reg [15:0] cause_r;
	reg        push_r;
	reg [15:0] push_code_r;
	reg [31:0] stg_lo_r;
	reg [7:0]  stg_hi_r;
	reg [15:0] offs_stg_r;
	reg [15:0] offs_r;
	reg [1:0]  unit_r;
	reg        log_sweep_r;
	reg [2:0]  mod_shape_r;
	reg [2:0]  arb_sel_r;
	reg        arb_user_r;
	reg [13:0] arb_pts_r;
	reg [1:0]  trig_src_r;
	reg        trig_slope_r;
	reg [15:0] err_q [0:3];
	reg [1:0]  eq_wr_r;
	reg [1:0]  eq_rd_r;
	reg [2:0]  eq_cnt_r;
	reg [2:0]  eq_cnt_nxt;
	reg [31:0] rdata_nxt;
	reg        addr_ok;

	wire [39:0] fmax     = f_max(shape_r, arb_user_r, arb_pts_r);
	wire [39:0] fmin     = f_min(shape_r, arb_user_r);
	wire [15:0] amax     = a_max(shape_r, unit_r);
	wire        fast     = freq_r > `WSV_F_5M;
	wire [7:0]  dlo      = fast ? `WSV_D_LO_NARR : `WSV_D_LO_WIDE;
	wire [7:0]  dhi      = fast ? `WSV_D_HI_NARR : `WSV_D_HI_WIDE;
	wire        done     = psel & penable & pready;
	wire        wr       = done & pwrite & addr_ok;
	wire        pop      = done & ~pwrite & (paddr == `WSV_A_ERR) & (eq_cnt_r != 3'h0);
	wire        no_carr  = (shape_r == `WSV_SH_NOISE) | (shape_r == `WSV_SH_DC);
	wire        wd_nocar = (pwdata[2:0] == `WSV_SH_NOISE) | (pwdata[2:0] == `WSV_SH_DC);
	wire        wd_shok  = pwdata[2:0] != 3'h7;

	// ==========================================
	// Address decode and read mux
	always @* begin
		addr_ok   = (paddr[1:0] == 2'b00) && (paddr <= `WSV_A_STATUS);
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`WSV_A_SHAPE:   rdata_nxt = {29'h0, shape_r};
			`WSV_A_FREQ_LO: rdata_nxt = freq_r[31:0];
			`WSV_A_FREQ_HI: rdata_nxt = {24'h0, freq_r[39:32]};
			`WSV_A_DUTY:    rdata_nxt = {24'h0, duty_r};
			`WSV_A_AMP:     rdata_nxt = {14'h0, unit_r, amp_r};
			`WSV_A_MOD:     rdata_nxt = {25'h0, mod_shape_r, log_sweep_r, mod_mode_r};
			`WSV_A_ARB:     rdata_nxt = {2'h0, arb_pts_r, 12'h0, arb_user_r, arb_sel_r};
			`WSV_A_OFFS:    rdata_nxt = {16'h0, offs_r};
			`WSV_A_TRIG:    rdata_nxt = {29'h0, trig_slope_r, trig_src_r};
			`WSV_A_ERR:     rdata_nxt = (eq_cnt_r != 3'h0) ?
				{16'h0, err_q[eq_rd_r]} : {16'h0, `WSV_E_NONE};
			`WSV_A_STATUS:  rdata_nxt = {27'h0, eq_cnt_r, state_r != S_IDLE, err_pending_r};
			default:        rdata_nxt = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// APB handshake: no answer while a change is still being settled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (done) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !pready && state_r == S_IDLE && !push_r) begin
			// A setup seen while busy is answered later, in the access phase
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			prdata  <= rdata_nxt;
		end
	end

	// ==========================================
	// Settings and clamp sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r      <= S_IDLE;
			chk_amp_r    <= 1'b0;
			cause_r      <= `WSV_E_CONFLICT;
			push_r       <= 1'b0;
			push_code_r  <= `WSV_E_NONE;
			shape_r      <= `WSV_SH_SINE;
			freq_r       <= `WSV_F_1K;
			stg_lo_r     <= F_DEF[31:0];
			stg_hi_r     <= F_DEF[39:32];
			duty_r       <= `WSV_D_DEF;
			amp_r        <= `WSV_AMP_DEF;
			unit_r       <= `WSV_U_VPP;
			offs_r       <= 16'h0000;
			offs_stg_r   <= 16'h0000;
			mod_mode_r   <= `WSV_MD_OFF;
			log_sweep_r  <= 1'b0;
			mod_shape_r  <= `WSV_SH_SINE;
			arb_sel_r    <= 3'h0;
			arb_user_r   <= 1'b0;
			arb_pts_r    <= 14'h0008;
			trig_src_r   <= 2'h0;
			trig_slope_r <= 1'b0;
		end else begin
			push_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (wr) begin
						case (paddr)
							`WSV_A_SHAPE: begin
								if (!wd_shok) begin
									push_r      <= 1'b1;
									push_code_r <= `WSV_E_ILLEGAL;
								end else begin
									shape_r   <= pwdata[2:0];
									if (wd_nocar)
										mod_mode_r <= `WSV_MD_OFF;
									cause_r   <= `WSV_E_CONFLICT;
									chk_amp_r <= 1'b1;
									state_r   <= S_FREQ;
								end
							end
							`WSV_A_FREQ_LO: stg_lo_r <= pwdata;
							`WSV_A_FREQ_HI: begin
								stg_hi_r  <= pwdata[7:0];
								freq_r    <= {pwdata[7:0], stg_lo_r};
								cause_r   <= `WSV_E_RANGE;
								chk_amp_r <= 1'b0;
								state_r   <= S_FREQ;
							end
							`WSV_A_DUTY: begin
								duty_r    <= pwdata[7:0];
								cause_r   <= `WSV_E_RANGE;
								chk_amp_r <= 1'b0;
								state_r   <= S_DUTY;
							end
							`WSV_A_AMP: begin
								amp_r   <= pwdata[15:0];
								unit_r  <= pwdata[17:16];
								cause_r <= (pwdata[17:16] != unit_r) ?
									`WSV_E_CONFLICT : `WSV_E_RANGE;
								state_r <= S_AMP;
							end
							`WSV_A_MOD: begin
								log_sweep_r <= pwdata[3];
								mod_shape_r <= (pwdata[6:4] <= `WSV_SH_USER) ?
									pwdata[6:4] : mod_shape_r;
								if (pwdata[2:0] > `WSV_MD_SWEEP) begin
									push_r      <= 1'b1;
									push_code_r <= `WSV_E_ILLEGAL;
								end else if (pwdata[2:0] != `WSV_MD_OFF && no_carr) begin
									mod_mode_r  <= `WSV_MD_OFF;
									push_r      <= 1'b1;
									push_code_r <= `WSV_E_CONFLICT;
								end else begin
									mod_mode_r  <= pwdata[2:0];
								end
							end
							`WSV_A_ARB: begin
								arb_sel_r  <= (pwdata[2:0] <= 3'h4) ? pwdata[2:0] : arb_sel_r;
								arb_user_r <= pwdata[3];
								arb_pts_r  <= pwdata[29:16];
								cause_r    <= `WSV_E_CONFLICT;
								chk_amp_r  <= 1'b0;
								state_r    <= S_FREQ;
							end
							`WSV_A_COMBINED_SETUP_CMD: begin
								if (!wd_shok) begin
									push_r      <= 1'b1;
									push_code_r <= `WSV_E_ILLEGAL;
								end else begin
									// Side effects on duty, mode and trigger are intended
									shape_r      <= pwdata[2:0];
									freq_r       <= {stg_hi_r, stg_lo_r};
									amp_r        <= pwdata[31:16];
									offs_r       <= offs_stg_r;
									duty_r       <= `WSV_D_DEF;
									mod_mode_r   <= `WSV_MD_OFF;
									trig_src_r   <= 2'h0;
									trig_slope_r <= 1'b0;
									cause_r      <= `WSV_E_CONFLICT;
									chk_amp_r    <= 1'b1;
									state_r      <= S_FREQ;
								end
							end
							`WSV_A_OFFS: offs_stg_r <= pwdata[15:0];
							`WSV_A_TRIG: begin
								trig_src_r   <= pwdata[1:0];
								trig_slope_r <= pwdata[2];
							end
							default: ;
						endcase
					end
				end
				S_FREQ: begin
					if (freq_r > fmax) begin
						freq_r      <= fmax;
						push_r      <= 1'b1;
						push_code_r <= cause_r;
					end else if (freq_r < fmin) begin
						freq_r      <= fmin;
						push_r      <= 1'b1;
						push_code_r <= cause_r;
					end
					if (cause_r == `WSV_E_RANGE)
						cause_r <= `WSV_E_CONFLICT;
					state_r <= S_DUTY;
				end
				S_DUTY: begin
					// Duty limits only mean something for the square shape
					if (shape_r == `WSV_SH_SQUARE && (duty_r < dlo || duty_r > dhi)) begin
						duty_r      <= (duty_r < dlo) ? dlo : dhi;
						push_r      <= 1'b1;
						push_code_r <= cause_r;
					end
					state_r <= chk_amp_r ? S_AMP : S_IDLE;
				end
				S_AMP: begin
					if (amp_r > amax) begin
						amp_r       <= amax;
						push_r      <= 1'b1;
						push_code_r <= cause_r;
					end
					chk_amp_r <= 1'b0;
					state_r   <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ==========================================
	// Error queue; a full queue drops the newest entry
	always @* begin
		eq_cnt_nxt = eq_cnt_r;
		if (push_r && eq_cnt_r != `WSV_EQ_DEPTH && !pop)
			eq_cnt_nxt = eq_cnt_r + 3'h1;
		else if (pop && !(push_r && eq_cnt_r != `WSV_EQ_DEPTH))
			eq_cnt_nxt = eq_cnt_r - 3'h1;
	end

	always @(posedge pclk) begin
		if (push_r && eq_cnt_r != `WSV_EQ_DEPTH)
			err_q[eq_wr_r] <= push_code_r;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_wr_r       <= 2'h0;
			eq_rd_r       <= 2'h0;
			eq_cnt_r      <= 3'h0;
			err_pending_r <= 1'b0;
		end else begin
			if (push_r && eq_cnt_r != `WSV_EQ_DEPTH)
				eq_wr_r <= eq_wr_r + 2'h1;
			if (pop)
				eq_rd_r <= eq_rd_r + 2'h1;
			eq_cnt_r      <= eq_cnt_nxt;
			err_pending_r <= eq_cnt_nxt != 3'h0;
		end
	end

endmodule // wsv_validator

// ==== design/wsv_consts.vh ====
`ifndef WSV_CONSTS_VH
`define WSV_CONSTS_VH

// ==========================================
// Register byte offsets
`define WSV_A_SHAPE    8'h00
`define WSV_A_FREQ_LO  8'h04
`define WSV_A_FREQ_HI  8'h08
`define WSV_A_DUTY     8'h0C
`define WSV_A_AMP      8'h10
`define WSV_A_MOD      8'h14
`define WSV_A_ARB      8'h18
`define WSV_A_COMBINED_SETUP_CMD    8'h1C
`define WSV_A_OFFS     8'h20
`define WSV_A_TRIG     8'h24
`define WSV_A_ERR      8'h28
`define WSV_A_STATUS   8'h2C

// ==========================================
// Shape codes
`define WSV_SH_SINE    3'h0
`define WSV_SH_SQUARE  3'h1
`define WSV_SH_TRI     3'h2
`define WSV_SH_RAMP    3'h3
`define WSV_SH_NOISE   3'h4
`define WSV_SH_USER    3'h5
`define WSV_SH_DC      3'h6

// ==========================================
// Modulation modes
`define WSV_MD_OFF     3'h0
`define WSV_MD_SWEEP   3'h5

// ==========================================
// Amplitude units
`define WSV_U_VPP      2'h0
`define WSV_U_VRMS     2'h1
`define WSV_U_DBM      2'h2

// ==========================================
// Frequency limits, units of 100 uHz
`define WSV_F_15M      40'h22_ECB2_5C00
`define WSV_F_5M       40'h0B_A43B_7400
`define WSV_F_2M5      40'h05_D21D_BA00
`define WSV_F_200K     40'h00_7735_9400
`define WSV_F_100K     40'h00_3B9A_CA00
`define WSV_F_1K       40'h00_0098_9680
`define WSV_F_MIN_STD  40'h00_0000_0001
`define WSV_F_MIN_USER 40'h00_0000_03E8
`define WSV_F_NONE_LO  40'h00_0000_0000
`define WSV_F_NONE_HI  40'hFF_FFFF_FFFF

// ==========================================
// User waveform point thresholds
`define WSV_PTS_8K     14'h2000
`define WSV_PTS_12K    14'h2FFF

// ==========================================
// Duty cycle limits in percent
`define WSV_D_LO_WIDE  8'h14
`define WSV_D_HI_WIDE  8'h50
`define WSV_D_LO_NARR  8'h28
`define WSV_D_HI_NARR  8'h3C
`define WSV_D_DEF      8'h32

// ==========================================
// Amplitude ceilings: mVrms and 0.01 dBm
`define WSV_AR_SINE    16'h0DCF
`define WSV_AR_SQUARE  16'h1388
`define WSV_AR_TRI     16'h0B47
`define WSV_AD_SINE    16'h095C
`define WSV_AD_SQUARE  16'h0A8A
`define WSV_AD_TRI     16'h08AA
`define WSV_A_NOLIM    16'hFFFF
`define WSV_AMP_DEF    16'h0064

// ==========================================
// Error codes, 16-bit two's complement
`define WSV_E_NONE     16'h0000
`define WSV_E_CONFLICT 16'hFF23
`define WSV_E_RANGE    16'hFF22
`define WSV_E_ILLEGAL  16'hFF20

`define WSV_EQ_DEPTH   3'h4

`endif

// ==== tb/wsv_validator_properties.sv ====
`include "wsv_consts.vh"
// ==========================================
// Port-level checks for the validator
module wsv_properties (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic [2:0]  shape_r,
	input logic [39:0] freq_r,
	input logic [7:0]  duty_r,
	input logic [15:0] amp_r,
	input logic [2:0]  mod_mode_r,
	input logic        err_pending_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hi_band;
	assign hi_band = freq_r > `WSV_F_5M;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Settings are judged only while answering or at reset release, since a change is mid-flight otherwise
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_answer_bound: assert property (psel && !penable |-> ##[1:8] pready)
		else $error("no answer to request");
	a_reset_shape: assert property ($rose(presetn) |-> shape_r == `WSV_SH_SINE && freq_r == `WSV_F_1K)
		else $error("bad shape or freq after reset");
	a_reset_queue: assert property ($rose(presetn) |-> !err_pending_r && mod_mode_r == `WSV_MD_OFF)
		else $error("bad queue or mode after reset");
	a_slow_ceiling: assert property (pready && shape_r inside {`WSV_SH_TRI, `WSV_SH_RAMP} |-> freq_r <= `WSV_F_100K)
		else $error("ramp or triangle too fast");
	a_fast_ceiling: assert property (pready && shape_r <= `WSV_SH_SQUARE |-> freq_r <= `WSV_F_15M)
		else $error("sine or square too fast");
	a_user_ceiling: assert property (pready && shape_r == `WSV_SH_USER |-> freq_r <= `WSV_F_5M)
		else $error("arbitrary too fast");
	a_square_duty: assert property (pready && shape_r == `WSV_SH_SQUARE |->
		duty_r >= (hi_band ? `WSV_D_LO_NARR : `WSV_D_LO_WIDE) &&
		duty_r <= (hi_band ? `WSV_D_HI_NARR : `WSV_D_HI_WIDE))
		else $error("square duty out of band");
	a_noise_unmod: assert property (pready && shape_r inside {`WSV_SH_NOISE, `WSV_SH_DC} |-> mod_mode_r == `WSV_MD_OFF)
		else $error("modulated noise or dc");
endmodule // wsv_properties

bind wsv_validator wsv_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .shape_r(shape_r), .freq_r(freq_r), .duty_r(duty_r),
	.amp_r(amp_r), .mod_mode_r(mod_mode_r), .err_pending_r(err_pending_r));

// ==== tb/wsv_host_model.sv ====
// ==========================================
// Host controller issuing APB configuration transfers
module wsv_host_model (
	input  logic        pclk,
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [7:0]  paddr,
	output logic [31:0] pwdata,
	input  logic        pready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// Callers end a sequence with the combined setup, as it overwrites earlier settings
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		@(posedge pclk);
		while (!pready && k < 40) begin
			k++;
			@(posedge pclk);
		end
		if (pready !== 1'b1) begin
			tb_waveform_setting_validator.n_fail++;
			$display("BAD pready exp 1 got 0");
			tb_waveform_setting_validator.complete_run();
		end
		// Released lines show garbage, not the last request
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule // wsv_host_model

// ==== tb/tb_waveform_setting_validator.sv ====
`include "wsv_consts.vh"
module tb_waveform_setting_validator;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err_pending_r;
	logic [7:0]  paddr, duty_r;
	logic [31:0] pwdata, prdata;
	logic [2:0]  shape_r, mod_mode_r;
	logic [39:0] freq_r, f;
	logic [15:0] amp_r;
	logic [16:0] exp_q[$];
	int          n_fail = 0;
	int          samples_checked = 0;
	int          i;
	logic [31:0] arb_w[6] = '{32'h2000_0008, 32'h2001_0008, 32'h2FFF_0008,
		32'h3000_0008, 32'h3E80_0008, 32'h0000_0002};
	logic [39:0] arb_f[6] = '{`WSV_F_5M, `WSV_F_2M5, `WSV_F_2M5, `WSV_F_200K,
		`WSV_F_200K, `WSV_F_5M};

	always #25 pclk = ~pclk;

	wsv_validator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shape_r(shape_r), .freq_r(freq_r), .duty_r(duty_r),
		.amp_r(amp_r), .mod_mode_r(mod_mode_r), .err_pending_r(err_pending_r));
	wsv_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready));

	// ==========================================
	// Compare, verdict and bus helpers
	task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [16:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 32'h0000_0000);
	endtask
	// An error read also waits out any processing still under way
	task err(input logic [15:0] e);
		rd(`WSV_A_ERR, {1'b0, e});
	endtask
	task set_f(input logic [39:0] v);
		wr(`WSV_A_FREQ_LO, v[31:0]);
		wr(`WSV_A_FREQ_HI, {24'h00_0000, v[39:32]});
	endtask

	// ==========================================
	// Read watcher
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			chk("read", {23'h00_0000, pslverr, prdata[15:0]}, {23'h00_0000, exp_q.pop_front()});
	end

	// ==========================================
	// Scenarios
	initial begin
		void'($urandom(46567));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("shape", shape_r, `WSV_SH_SINE);
		chk("freq", freq_r, `WSV_F_1K);
		chk("pending", err_pending_r, 0);
		err(`WSV_E_NONE);
		rd(8'h30, 17'h1_0000);
		$display("reset test done");
		for (i = 0; i < 7; i++) begin
			wr(`WSV_A_SHAPE, 32'(i));
			err(`WSV_E_NONE);
			chk("shape", shape_r, i[2:0]);
		end
		wr(`WSV_A_SHAPE, 32'h0000_0007);
		err(`WSV_E_ILLEGAL);
		chk("shape", shape_r, `WSV_SH_DC);
		$display("shape test done");
		for (i = 0; i < 2; i++) begin
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SINE});
			f = `WSV_F_100K + 40'h1 + 40'($urandom_range(0, 32'h0FFF_FFFF));
			set_f(f);
			err(`WSV_E_NONE);
			wr(`WSV_A_SHAPE, {29'h0, (i == 0) ? `WSV_SH_TRI : `WSV_SH_RAMP});
			rd(`WSV_A_STATUS, 17'h0_0005);
			err(`WSV_E_CONFLICT);
			chk("freq", freq_r, `WSV_F_100K);
			chk("pending", err_pending_r, 0);
		end
		$display("shape clamp test done");
		wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SQUARE});
		for (i = 0; i < 2; i++) begin
			set_f(`WSV_F_1K);
			wr(`WSV_A_DUTY, (i == 0) ? 32'h0000_0046 : 32'h0000_001E);
			set_f(`WSV_F_5M + 40'h1 + 40'($urandom));
			err(`WSV_E_CONFLICT);
			chk("duty", duty_r, (i == 0) ? `WSV_D_HI_NARR : `WSV_D_LO_NARR);
		end
		set_f(`WSV_F_1K);
		wr(`WSV_A_DUTY, 32'h0000_0046);
		set_f(`WSV_F_5M);
		err(`WSV_E_NONE);
		chk("duty", duty_r, 8'h46);
		$display("duty test done");
		for (i = 0; i < 6; i++) begin
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SINE});
			set_f(`WSV_F_15M);
			wr(`WSV_A_ARB, arb_w[i]);
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_USER});
			err(`WSV_E_CONFLICT);
			err(`WSV_E_NONE);
			chk("freq", freq_r, arb_f[i]);
		end
		$display("arbitrary test done");
		for (i = 1; i < 6; i++) begin
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SINE});
			// Noise as modulating wave with log sweep; both must be kept
			wr(`WSV_A_MOD, 32'h0000_0048 | 32'(i));
			err(`WSV_E_NONE);
			rd(`WSV_A_MOD, 17'h0_0048 | 17'(i));
			chk("mode", mod_mode_r, i[2:0]);
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_NOISE});
			err(`WSV_E_NONE);
			chk("mode", mod_mode_r, `WSV_MD_OFF);
		end
		wr(`WSV_A_MOD, 32'h0000_0002);
		err(`WSV_E_CONFLICT);
		wr(`WSV_A_MOD, 32'h0000_0006);
		err(`WSV_E_ILLEGAL);
		chk("mode", mod_mode_r, `WSV_MD_OFF);
		$display("modulation test done");
		for (i = 0; i < 2; i++) begin
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SQUARE});
			wr(`WSV_A_AMP, (i == 0) ? {14'h0, `WSV_U_VRMS, `WSV_AR_SQUARE}
				: {14'h0, `WSV_U_DBM, `WSV_AD_SQUARE});
			err(`WSV_E_NONE);
			wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SINE});
			err(`WSV_E_CONFLICT);
			chk("amp", amp_r, (i == 0) ? `WSV_AR_SINE : `WSV_AD_SINE);
		end
		$display("amplitude test done");
		wr(`WSV_A_SHAPE, {29'h0, `WSV_SH_SQUARE});
		wr(`WSV_A_MOD, 32'h0000_0001);
		f = `WSV_F_1K + 40'($urandom_range(0, 1000));
		set_f(f);
		err(`WSV_E_NONE);
		wr(`WSV_A_COMBINED_SETUP_CMD, {`WSV_AMP_DEF, 13'h0, `WSV_SH_SINE});
		err(`WSV_E_NONE);
		chk("shape", shape_r, `WSV_SH_SINE);
		chk("freq", freq_r, f);
		chk("amp", amp_r, `WSV_AMP_DEF);
		chk("mode", mod_mode_r, `WSV_MD_OFF);
		chk("duty", duty_r, `WSV_D_DEF);
		$display("setup test done");
		complete_run();
	end
endmodule // tb_waveform_setting_validator
